// [bmc_pkg.sv]
`default_nettype none

package bmc_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int unsigned BMC_DATA_W = 32;
  localparam int unsigned BMC_REG_W = 8;
  localparam int unsigned BMC_ADDR_LSB = 2;
  localparam int unsigned BMC_STRB_W = 4;
  localparam logic [7:0] BMC_IDX_BIAS = 8'h08;
  localparam logic [7:0] BMC_IDX_MON = 8'h09;
  localparam logic [7:0] BMC_BIAS_RST = 8'h00;
  localparam logic [7:0] BMC_MON_RST = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned BMC_LEVEL_BIT = 7;
  localparam int unsigned BMC_CONN_MSB = 6;
  localparam int unsigned BMC_MONSEL_MSB = 7;
  localparam int unsigned BMC_MONSEL_LSB = 5;
  localparam int unsigned BMC_AVG_MSB = 4;
  localparam int unsigned BMC_AVG_LSB = 3;
  localparam int unsigned BMC_TIMEOUT_BIT = 2;
  localparam int unsigned BMC_CRC_BIT = 1;
  localparam int unsigned BMC_STAT_BIT = 0;

  // ----------------------------------------------------------------
  // Monitor codes, burn-out levels and averaging counts
  // ----------------------------------------------------------------
  localparam logic [2:0] BMC_MON_OFF = 3'h0;
  localparam logic [2:0] BMC_MON_MID = 3'h1;
  localparam logic [2:0] BMC_MON_TEMP = 3'h2;
  localparam logic [2:0] BMC_MON_ASUP = 3'h3;
  localparam logic [2:0] BMC_MON_DSUP = 3'h4;
  localparam logic [2:0] BMC_MON_BO_LOW = 3'h5;
  localparam logic [2:0] BMC_MON_BO_MID = 3'h6;
  localparam logic [2:0] BMC_MON_BO_HIGH = 3'h7;
  localparam logic [1:0] BMC_BO_NONE = 2'h0;
  localparam logic [1:0] BMC_BO_0U2 = 2'h1;
  localparam logic [1:0] BMC_BO_1U = 2'h2;
  localparam logic [1:0] BMC_BO_10U = 2'h3;
  localparam logic [1:0] BMC_AMP_ON = 2'h1;
  localparam logic [1:0] BMC_AVG_1 = 2'h0;
  localparam logic [1:0] BMC_AVG_4 = 2'h1;
  localparam logic [1:0] BMC_AVG_8 = 2'h2;
  localparam logic [1:0] BMC_AVG_16 = 2'h3;
  localparam logic [4:0] BMC_SAMP_1 = 5'h01;
  localparam logic [4:0] BMC_SAMP_4 = 5'h04;
  localparam logic [4:0] BMC_SAMP_8 = 5'h08;
  localparam logic [4:0] BMC_SAMP_16 = 5'h10;

endpackage

`default_nettype wire

// [bmc_mon_decode.sv]
`timescale 1ns/1ps
`default_nettype none

module bmc_mon_decode
  import bmc_pkg::*;
(
  input wire logic [2:0] mon_code, // Monitor selection code.
  input wire logic [1:0] avg_code, // Averaging count code.
  output logic mid_short, // Amplifier inputs shorted to mid-supply.
  output logic temp_en, // Temperature sensor routed to converter.
  output logic asup_mon, // Analog supply span over four measured.
  output logic dsup_mon, // Digital supply over four measured.
  output logic gain_one, // Amplifier gain forced to one.
  output logic mux_open, // External input switches opened.
  output logic [1:0] burnout, // Burn-out current setting.
  output logic [4:0] samples // Conversions averaged in calibration.
);

  // ----------------------------------------------------------------
  // Monitor decode
  // ----------------------------------------------------------------

  // Turns the monitor code into one control line per analog function.
  always_comb
  begin
    mid_short = 1'b0;
    temp_en = 1'b0;
    asup_mon = 1'b0;
    dsup_mon = 1'b0;
    burnout = BMC_BO_NONE;
    case (mon_code)
      BMC_MON_OFF: mid_short = 1'b0;
      BMC_MON_MID: mid_short = 1'b1;
      BMC_MON_TEMP: temp_en = 1'b1;
      BMC_MON_ASUP: asup_mon = 1'b1;
      BMC_MON_DSUP: dsup_mon = 1'b1;
      BMC_MON_BO_LOW: burnout = BMC_BO_0U2;
      BMC_MON_BO_MID: burnout = BMC_BO_1U;
      BMC_MON_BO_HIGH: burnout = BMC_BO_10U;
      default: burnout = BMC_BO_NONE;
    endcase
  end

  // Supply monitors override the user gain; internal paths open the switches.
  assign gain_one = asup_mon | dsup_mon;
  assign mux_open = mid_short | temp_en | asup_mon | dsup_mon;

  // Maps the averaging code onto the number of conversions.
  always_comb
  begin
    case (avg_code)
      BMC_AVG_1: samples = BMC_SAMP_1;
      BMC_AVG_4: samples = BMC_SAMP_4;
      BMC_AVG_8: samples = BMC_SAMP_8;
      BMC_AVG_16: samples = BMC_SAMP_16;
      default: samples = BMC_SAMP_8;
    endcase
  end

endmodule

`default_nettype wire

// [bmc_regs.sv]
`timescale 1ns/1ps
`default_nettype none

module bmc_regs
  import bmc_pkg::*;
#(
  parameter int unsigned PADDR_W = 12
)
(
  input wire logic pclk, // Bus clock, 50 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes all state while low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [PADDR_W-1:0] paddr, // APB byte address.
  input wire logic [BMC_DATA_W-1:0] pwdata, // APB write data.
  input wire logic [BMC_STRB_W-1:0] pstrb, // APB byte strobes.
  output logic [BMC_DATA_W-1:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped address.
  input wire logic [1:0] amp_enable, // Amplifier enable field.
  output logic bias_level_sel, // Bias level, high for one twelfth.
  output logic bias_gen_pd, // Bias generator power-down.
  output logic [6:0] bias_connect, // Bit 6 common input, 5:0 inputs.
  output logic [2:0] monitor_select, // Active monitor code.
  output logic mid_short_en, // Amplifier inputs at mid-supply.
  output logic temp_sensor_en, // Temperature sensor selected.
  output logic asup_mon_en, // Analog supply monitor selected.
  output logic dsup_mon_en, // Digital supply monitor selected.
  output logic gain_force_one, // Amplifier gain forced to one.
  output logic input_mux_open, // External input switches open.
  output logic [1:0] burnout_level, // Burn-out current setting.
  output logic [1:0] cal_average_count, // Averaging code.
  output logic [4:0] cal_samples, // Conversions averaged.
  output logic timeout_en, // Serial timeout enable.
  output logic crc_en, // CRC append enable.
  output logic status_prefix_en, // Status byte prepend enable.
  output logic temp_amp_err // Temperature chosen without amplifier.
);

  localparam int unsigned IDX_W = PADDR_W - BMC_ADDR_LSB;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (PADDR_W < 8 || PADDR_W > 32)
  begin : g_bad_width
    $error("PADDR_W must lie between 8 and 32");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] bias;
    logic [7:0] mon;
    logic [7:0] rdata;
    logic slverr;
    logic acc_ok;
    logic [6:0] conn;
    logic level;
    logic pd;
    logic [2:0] mon_sel;
    logic mid;
    logic temp;
    logic asup;
    logic dsup;
    logic gain1;
    logic mopen;
    logic [1:0] burn;
    logic [1:0] avg;
    logic [4:0] samp;
    logic tmo;
    logic crc;
    logic stat;
    logic terr;
  } bmc_state_s;

  bmc_state_s st_ff;
  bmc_state_s nxt_st;

  logic [IDX_W-1:0] idx;
  logic hit_bias;
  logic hit_mon;
  logic done;
  logic wr_done;
  logic d_mid;
  logic d_temp;
  logic d_asup;
  logic d_dsup;
  logic d_gain1;
  logic d_mopen;
  logic [1:0] d_burn;
  logic [4:0] d_samp;

  // ----------------------------------------------------------------
  // Address decode and handshake
  // ----------------------------------------------------------------

  // Word index decode; each register takes one aligned word.
  assign idx = paddr[PADDR_W-1:BMC_ADDR_LSB];
  assign hit_bias = (idx == IDX_W'(BMC_IDX_BIAS));
  assign hit_mon = (idx == IDX_W'(BMC_IDX_MON));

  // Ready waits until read data was captured on an enabled edge.
  assign pready = psel & penable & st_ff.acc_ok & clk_en;
  assign done = psel & penable & pready;
  assign wr_done = done & pwrite & pstrb[0];

  // ----------------------------------------------------------------
  // Monitor decoder
  // ----------------------------------------------------------------
  bmc_mon_decode u_dec (
    .mon_code (st_ff.mon[BMC_MONSEL_MSB:BMC_MONSEL_LSB]),
    .avg_code (st_ff.mon[BMC_AVG_MSB:BMC_AVG_LSB]),
    .mid_short (d_mid),
    .temp_en (d_temp),
    .asup_mon (d_asup),
    .dsup_mon (d_dsup),
    .gain_one (d_gain1),
    .mux_open (d_mopen),
    .burnout (d_burn),
    .samples (d_samp)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  // Register writes, read capture and registered decode of stored values.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.acc_ok = psel & ~done;
    if (psel)
    begin
      nxt_st.slverr = ~(hit_bias | hit_mon);
      if (hit_bias)
      begin
        nxt_st.rdata = st_ff.bias;
      end
      else if (hit_mon)
      begin
        nxt_st.rdata = st_ff.mon;
      end
      else
      begin
        nxt_st.rdata = 8'h00;
      end
    end
    if (wr_done && hit_bias)
    begin
      nxt_st.bias = pwdata[BMC_REG_W-1:0];
    end
    if (wr_done && hit_mon)
    begin
      nxt_st.mon = pwdata[BMC_REG_W-1:0];
    end
    // Outputs follow the stored registers one edge later; the amplifier flag one edge after that.
    nxt_st.level = st_ff.bias[BMC_LEVEL_BIT];
    nxt_st.conn = st_ff.bias[BMC_CONN_MSB:0];
    nxt_st.pd = (st_ff.bias[BMC_CONN_MSB:0] == 7'h00);
    nxt_st.mon_sel = st_ff.mon[BMC_MONSEL_MSB:BMC_MONSEL_LSB];
    nxt_st.mid = d_mid;
    nxt_st.temp = d_temp;
    nxt_st.asup = d_asup;
    nxt_st.dsup = d_dsup;
    nxt_st.gain1 = d_gain1;
    nxt_st.mopen = d_mopen;
    nxt_st.burn = d_burn;
    nxt_st.avg = st_ff.mon[BMC_AVG_MSB:BMC_AVG_LSB];
    nxt_st.samp = d_samp;
    nxt_st.tmo = st_ff.mon[BMC_TIMEOUT_BIT];
    nxt_st.crc = st_ff.mon[BMC_CRC_BIT];
    nxt_st.stat = st_ff.mon[BMC_STAT_BIT];
    nxt_st.terr = st_ff.temp & (amp_enable != BMC_AMP_ON);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Reset loads the documented register values and their decode.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0;
      st_ff.bias <= BMC_BIAS_RST;
      st_ff.mon <= BMC_MON_RST;
      st_ff.pd <= 1'b1;
      st_ff.avg <= BMC_AVG_8;
      st_ff.samp <= BMC_SAMP_8;
    end
    else if (clk_en)
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Every output except pready comes straight from the state register.
  assign prdata = {24'h000000, st_ff.rdata};
  assign pslverr = st_ff.slverr;
  assign bias_level_sel = st_ff.level;
  assign bias_gen_pd = st_ff.pd;
  assign bias_connect = st_ff.conn;
  assign monitor_select = st_ff.mon_sel;
  assign mid_short_en = st_ff.mid;
  assign temp_sensor_en = st_ff.temp;
  assign asup_mon_en = st_ff.asup;
  assign dsup_mon_en = st_ff.dsup;
  assign gain_force_one = st_ff.gain1;
  assign input_mux_open = st_ff.mopen;
  assign burnout_level = st_ff.burn;
  assign cal_average_count = st_ff.avg;
  assign cal_samples = st_ff.samp;
  assign timeout_en = st_ff.tmo;
  assign crc_en = st_ff.crc;
  assign status_prefix_en = st_ff.stat;
  assign temp_amp_err = st_ff.terr;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  // A completed write to each register.
  sequence s_bias_wr;
    wr_done && hit_bias;
  endsequence

  sequence s_mon_wr;
    wr_done && hit_mon;
  endsequence

  property p_bias_store;
    @(posedge pclk) disable iff (!presetn)
    s_bias_wr |=> st_ff.bias == $past(pwdata[BMC_REG_W-1:0]);
  endproperty
  a_bias_store: assert property (p_bias_store) else $error("bias write lost");

  property p_bias_read;
    @(posedge pclk) disable iff (!presetn)
    (done && !pwrite && hit_bias) |-> prdata[BMC_REG_W-1:0] == st_ff.bias && !pslverr;
  endproperty
  a_bias_read: assert property (p_bias_read) else $error("bias read wrong");

  property p_level;
    @(posedge pclk) disable iff (!presetn)
    s_bias_wr ##1 clk_en |=> bias_level_sel == $past(pwdata[BMC_LEVEL_BIT], 2);
  endproperty
  a_level: assert property (p_level) else $error("bias level not applied");

  property p_pd;
    @(posedge pclk) disable iff (!presetn)
    bias_gen_pd == (bias_connect == 7'h00);
  endproperty
  a_pd: assert property (p_pd) else $error("bias power-down wrong");

  property p_conn;
    @(posedge pclk) disable iff (!presetn)
    s_bias_wr ##1 clk_en |=> bias_connect == $past(pwdata[BMC_CONN_MSB:0], 2);
  endproperty
  a_conn: assert property (p_conn) else $error("bias connect not applied");

  property p_mon_store;
    @(posedge pclk) disable iff (!presetn)
    s_mon_wr |=> st_ff.mon == $past(pwdata[BMC_REG_W-1:0]);
  endproperty
  a_mon_store: assert property (p_mon_store) else $error("monitor write lost");

  property p_mid;
    @(posedge pclk) disable iff (!presetn)
    mid_short_en |-> input_mux_open && !gain_force_one && monitor_select == BMC_MON_MID;
  endproperty
  a_mid: assert property (p_mid) else $error("mid-supply short wrong");

  property p_temp;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && temp_sensor_en && amp_enable != BMC_AMP_ON) |=> temp_amp_err;
  endproperty
  a_temp: assert property (p_temp) else $error("missing amplifier flag");

  property p_gain;
    @(posedge pclk) disable iff (!presetn)
    gain_force_one == (asup_mon_en || dsup_mon_en);
  endproperty
  a_gain: assert property (p_gain) else $error("gain override wrong");

  property p_burn;
    @(posedge pclk) disable iff (!presetn)
    (monitor_select >= BMC_MON_BO_LOW) |-> burnout_level == monitor_select[1:0];
  endproperty
  a_burn: assert property (p_burn) else $error("burn-out level wrong");

  property p_avg;
    @(posedge pclk) disable iff (!presetn)
    (cal_average_count == BMC_AVG_16) |-> cal_samples == BMC_SAMP_16;
  endproperty
  a_avg: assert property (p_avg) else $error("averaging count wrong");

  property p_flags;
    @(posedge pclk) disable iff (!presetn)
    s_mon_wr ##1 clk_en |=>
      {timeout_en, crc_en, status_prefix_en} == $past(pwdata[BMC_TIMEOUT_BIT:BMC_STAT_BIT], 2);
  endproperty
  a_flags: assert property (p_flags) else $error("serial flags not applied");

  property p_mux;
    @(posedge pclk) disable iff (!presetn)
    input_mux_open == (mid_short_en || temp_sensor_en || asup_mon_en || dsup_mon_en);
  endproperty
  a_mux: assert property (p_mux) else $error("input switches wrong");

endmodule

`default_nettype wire

// [bias_and_monitor_ctrl_regs_test.sv]
`timescale 1ns/1ps
`default_nettype none

module bias_and_monitor_ctrl_regs_test;
  import bmc_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hf;
  logic [1:0] amp_enable = 2'h0;
  logic [31:0] prdata;
  logic pready, pslverr, bias_level_sel, bias_gen_pd, mid_short_en, temp_sensor_en;
  logic asup_mon_en, dsup_mon_en, gain_force_one, input_mux_open, timeout_en, crc_en;
  logic status_prefix_en, temp_amp_err;
  logic [6:0] bias_connect;
  logic [2:0] monitor_select;
  logic [1:0] burnout_level, cal_average_count;
  logic [4:0] cal_samples;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  int waits = 0;
  integer seed = 32'h0297bcb5;
  localparam logic [7:0] BIAS_CORNER [4] = '{8'h80, 8'h7f, 8'hff, 8'h41};

  // Clock at 50 MHz.
  always #10 pclk = ~pclk;

  bmc_regs #(.PADDR_W(12)) i_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .amp_enable(amp_enable),
    .bias_level_sel(bias_level_sel), .bias_gen_pd(bias_gen_pd), .bias_connect(bias_connect),
    .monitor_select(monitor_select), .mid_short_en(mid_short_en),
    .temp_sensor_en(temp_sensor_en), .asup_mon_en(asup_mon_en), .dsup_mon_en(dsup_mon_en),
    .gain_force_one(gain_force_one), .input_mux_open(input_mux_open),
    .burnout_level(burnout_level), .cal_average_count(cal_average_count),
    .cal_samples(cal_samples), .timeout_en(timeout_en), .crc_en(crc_en),
    .status_prefix_en(status_prefix_en), .temp_amp_err(temp_amp_err)
  );

  // ----------------------------------------------------------------
  // Comparison, verdict and expectation helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Averaging code to sample count.
  function automatic logic [4:0] exp_samp(input logic [1:0] a);
    case (a)
      2'h0: return 5'h01;
      2'h1: return 5'h04;
      2'h2: return 5'h08;
      default: return 5'h10;
    endcase
  endfunction

  // Burn-out level: codes five to seven give levels one to three.
  function automatic logic [1:0] exp_bo(input logic [2:0] c);
    return (c >= 3'h5) ? 2'(c - 3'h4) : 2'h0;
  endfunction

  // ----------------------------------------------------------------
  // APB master: holds the request until pready is seen high at an edge
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input int hold);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    if (hold > 0)
      clk_en <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    waits = 0;
    do
    begin
      @(posedge pclk);
      waits++;
      if (waits == hold)
        clk_en <= 1'b1;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Write a register with random unused upper data bits.
  task automatic wreg(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    r = $random(seed);
    apb(1'b1, a, {r[31:8], d}, 4'hf, 0);
  endtask

  task automatic rreg(input logic [11:0] a, input logic [7:0] exp, input logic experr);
    apb(1'b0, a, 32'h00000000, 4'hf, 0);
    check("prdata", rd, {24'h000000, exp});
    check("pslverr", err, experr);
  endtask

  // Decoded outputs land one edge after the store, the amplifier flag one more.
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic check_bias(input logic [7:0] v);
    check("bias_level_sel", bias_level_sel, v[7]);
    check("bias_connect", bias_connect, v[6:0]);
    check("bias_gen_pd", bias_gen_pd, v[6:0] == 7'h00);
  endtask

  task automatic check_mon(input logic [7:0] v, input logic [1:0] amp);
    logic [2:0] c;
    c = v[7:5];
    check("monitor_select", monitor_select, c);
    check("mid_short_en", mid_short_en, c == 3'h1);
    check("temp_sensor_en", temp_sensor_en, c == 3'h2);
    check("temp_amp_err", temp_amp_err, c == 3'h2 && amp != 2'h1);
    check("asup_mon_en", asup_mon_en, c == 3'h3);
    check("dsup_mon_en", dsup_mon_en, c == 3'h4);
    check("gain_force_one", gain_force_one, c == 3'h3 || c == 3'h4);
    check("input_mux_open", input_mux_open, c >= 3'h1 && c <= 3'h4);
    check("burnout_level", burnout_level, exp_bo(c));
    check("cal_average_count", cal_average_count, v[4:3]);
    check("cal_samples", cal_samples, exp_samp(v[4:3]));
    check("timeout_en", timeout_en, v[2]);
    check("crc_en", crc_en, v[1]);
    check("status_prefix_en", status_prefix_en, v[0]);
  endtask

  task automatic check_reset(input logic [1:0] amp);
    check_bias(8'h00);
    check_mon(8'h10, amp);
    rreg(12'h020, 8'h00, 1'b0);
    rreg(12'h024, 8'h10, 1'b0);
  endtask

  // Cuts a hung run short.
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int i;
    logic [31:0] r;
    logic [7:0] v, b, m;
    logic [1:0] amp;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    check_reset(2'h0);
    $display("Test reset values done");
    b = 8'h00;
    for (i = 0; i < 24; i++)
    begin
      r = $random(seed);
      v = (i < 4) ? BIAS_CORNER[i] : r[7:0];
      wreg(12'h020, v);
      #1;
      check("bias_connect_early", bias_connect, b[6:0]);
      settle();
      check_bias(v);
      rreg(12'h020, v, 1'b0);
      b = v;
    end
    $display("Test bias register done");
    for (i = 0; i < 16; i++)
    begin
      r = $random(seed);
      m = {3'(i), r[4:0]};
      // The host keeps the amplifier on for the first eight iterations; iteration ten forces it off, the rest are random.
      amp = (i < 8) ? 2'h1 : ((i == 10) ? 2'h0 : r[9:8]);
      amp_enable <= amp;
      wreg(12'h024, m);
      settle();
      check_mon(m, amp);
      rreg(12'h024, m, 1'b0);
    end
    $display("Test monitor register done");
    apb(1'b1, 12'h020, 32'h0000005a, 4'he, 0);
    settle();
    check_bias(b);
    apb(1'b1, 12'h028, 32'h000000ff, 4'hf, 0);
    check("pslverr_write", err, 1'b1);
    rreg(12'h028, 8'h00, 1'b1);
    rreg(12'h020, b, 1'b0);
    rreg(12'h024, m, 1'b0);
    $display("Test refused accesses done");
    apb(1'b1, 12'h020, 32'h0000003c, 4'hf, 3);
    check("stall_wait", waits > 3, 1'b1);
    settle();
    check_bias(8'h3c);
    apb(1'b0, 12'h024, 32'h00000000, 4'hf, 2);
    check("prdata_stalled", rd, {24'h000000, m});
    $display("Test stalled transfers done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    check_reset(amp);
    $display("Test second reset done");
    tally_and_finish();
  end

endmodule

`default_nettype wire
